// ===== pkg/asr_map.svh
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

// ****************************************************************
// Result framing
// ****************************************************************
`define ASR_RESULT_BITS      16
`define ASR_FRAME_PLAIN      5'h10
`define ASR_FRAME_BUSY       5'h11
`define ASR_BITCNT_RESET     5'h00

// ****************************************************************
// Conversion timing
// ****************************************************************
`define ASR_CLK_PERIOD_NS    100
`define ASR_CONV_TIME_NS     5000
`define ASR_CONV_CYCLES \
    ((`ASR_CONV_TIME_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)

`endif

// ===== pkg/asr_pkg.sv
package asr_pkg;

    typedef enum logic [1:0] {
        ASR_IDLE,
        ASR_CONVERT,
        ASR_READY,
        ASR_RELEASED
    } asr_state_type;

endpackage

// ===== pkg/asr_shift_if.sv
interface asr_shift_if #(
    parameter int WIDTH = 16
);
    logic             load;
    logic [WIDTH-1:0] load_val;
    logic             shift;
    logic             ser_in;
    logic             msb;

    modport ctrl    (output load, output load_val, output shift,
                     output ser_in, input msb);
    modport shifter (input load, input load_val, input shift,
                     input ser_in, output msb);
endinterface

// ===== rtl/asr_shifter.sv
module asr_shifter #(
    parameter int WIDTH = 16
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    asr_shift_if.shifter     sh
);
    logic [WIDTH-1:0] data_q;

    // Load wins over shift so a new result is never corrupted
    always_ff @(posedge clk) begin
        if (reset) begin
            data_q <= '0;
        end else if (clk_en) begin
            if (sh.load) begin
                data_q <= sh.load_val;
            end else if (sh.shift) begin
                data_q <= {data_q[WIDTH-2:0], sh.ser_in};
            end
        end
    end

    assign sh.msb = data_q[WIDTH-1];
endmodule

// ===== rtl/asr_readout.sv
// Functional notes
// [RULE1] Trigger rise samples select level for mode
// [RULE2] Host waits max conversion without busy
// [RULE3] Select-mode trigger starts conversion, output floats
// [RULE4] Host holds trigger high in select mode
// [RULE5] Select and trigger low drive output low
// [RULE6] Host returns select high before min time
// [RULE7] Host returns select low for busy
// [RULE8] Busy select mode: output low at completion
// [RULE9] Completion enters standby until next trigger
// [RULE10] Select low after conversion shows MSB
// [RULE11] Shift MSB first on each clock fall
// [RULE12] No busy: float after 16 falls
// [RULE13] Busy: float after 17 falls or select
// [RULE14] Host captures on either clock edge
// [RULE15] Clock low at trigger: chain, no busy
// [RULE16] Host holds trigger high in chain
// [RULE17] Chain no busy: MSB at completion
// [RULE18] Chain input shifts in on falls
// [RULE19] Host gives 16 clocks per device
// [RULE20] Clock high at trigger: chain with busy
// [RULE21] Chain busy: drive high when done
// [RULE22] Host gives 16N+1 clocks with busy
// [RULE23] Conversion time is a cycle count
// [RULE24] Result loaded at completion before readout
`include "asr_map.svh"

module asr_readout
    import asr_pkg::*;
#(
    parameter int CONV_CYCLES = `ASR_CONV_CYCLES,
    parameter int DATA_W      = `ASR_RESULT_BITS
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire logic              conv_trigger,
    input  wire logic              chain_in_select,
    input  wire logic              sck,
    input  wire logic [DATA_W-1:0] sample_data,
    output      logic              result_out,
    output      logic              result_out_oe,
    output      logic              conv_active,
    output      logic              chain_mode
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic trig_s1_q;
    logic trig_s2_q;
    logic trig_d_q;
    logic sel_s1_q;
    logic sel_s2_q;
    logic sel_d_q;
    logic sck_s1_q;
    logic sck_s2_q;
    logic sck_d_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_d_q  <= 1'b0;
            sel_s1_q  <= 1'b0;
            sel_s2_q  <= 1'b0;
            sel_d_q   <= 1'b0;
            sck_s1_q  <= 1'b0;
            sck_s2_q  <= 1'b0;
            sck_d_q   <= 1'b0;
        end else if (clk_en) begin
            trig_s1_q <= conv_trigger;
            trig_s2_q <= trig_s1_q;
            trig_d_q  <= trig_s2_q;
            sel_s1_q  <= chain_in_select;
            sel_s2_q  <= sel_s1_q;
            sel_d_q   <= sel_s2_q;
            sck_s1_q  <= sck;
            sck_s2_q  <= sck_s1_q;
            sck_d_q   <= sck_s2_q;
        end
    end

    wire trig_rise = trig_s2_q & ~trig_d_q;
    wire trig_fall = ~trig_s2_q & trig_d_q;
    wire sel_rise  = sel_s2_q & ~sel_d_q;
    wire sck_fall  = ~sck_s2_q & sck_d_q;

    // ****************************************************************
    // Control state
    // ****************************************************************
    localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

    asr_state_type state_q;
    asr_state_type state_d;
    logic          chain_q;
    logic          chain_d;
    logic          busy_en_q;
    logic          busy_en_d;
    logic          start_q;
    logic          start_d;
    logic [15:0]   cnt_q;
    logic [15:0]   cnt_d;
    logic [4:0]    bits_q;
    logic [4:0]    bits_d;
    logic          out_q;
    logic          oe_q;
    logic          out_d;
    logic          oe_d;
    logic          sh_next_msb;
    logic [DATA_W-1:0] sh_mirror_q;

    asr_shift_if #(.WIDTH(DATA_W)) sh ();

    // Select level is taken from the cycle before the edge, so a select
    // input wired to the trigger always lands in chain mode
    wire cs_sel   = sel_d_q;
    wire conv_end = (state_q == ASR_CONVERT) && (cnt_q == 16'h0000);
    wire in_ready = (state_q == ASR_READY);

    // Select mode only moves data while the host selects the part;
    // with busy mode enabled the part already owns the line
    wire cs_drive = ~sel_s2_q | busy_en_q;
    wire fall_use = in_ready & sck_fall & (chain_q | cs_drive);
    wire [4:0] frame_len = busy_en_q ? `ASR_FRAME_BUSY : `ASR_FRAME_PLAIN;
    wire [4:0] bits_inc  = bits_q + 5'h01;
    wire       frame_end = ~chain_q & fall_use & (bits_inc == frame_len);

    // [RULE23] Completion counted
    // [RULE24] Result load at completion
    assign sh.load     = conv_end;
    assign sh.load_val = sample_data;
    // [RULE11] Shift MSB first
    // [RULE18] Chain input shifts in
    assign sh.shift    = fall_use & ~start_q;
    assign sh.ser_in   = sel_s2_q;

    asr_shifter #(.WIDTH(DATA_W)) u_shifter (
        .clk    (clk),
        .reset  (reset),
        .clk_en (clk_en),
        .sh     (sh)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        state_d   = state_q;
        chain_d   = chain_q;
        busy_en_d = busy_en_q;
        start_d   = start_q;
        cnt_d     = cnt_q;
        bits_d    = bits_q;
        case (state_q)
            ASR_CONVERT: begin
                // A started conversion always runs to its end
                if (conv_end) begin
                    // [RULE9] Enter standby phase
                    state_d = ASR_READY;
                    bits_d  = `ASR_BITCNT_RESET;
                    if (!chain_q) begin
                        busy_en_d = ~sel_s2_q;
                        start_d   = ~sel_s2_q;
                    end else begin
                        start_d = busy_en_q;
                    end
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            ASR_READY: begin
                if (trig_fall) begin
                    state_d = ASR_IDLE;
                // [RULE12] Release on select rise
                // [RULE13] Release on select rise
                end else if (!chain_q && sel_rise) begin
                    state_d = ASR_RELEASED;
                end else if (fall_use) begin
                    start_d = 1'b0;
                    bits_d  = bits_inc;
                    // [RULE12] Release after 16 falls
                    // [RULE13] Release after 17 falls
                    if (frame_end) begin
                        state_d = ASR_RELEASED;
                    end
                end
            end
            ASR_IDLE, ASR_RELEASED: begin
                if (trig_rise) begin
                    // [RULE1] Mode sampled at trigger
                    state_d = ASR_CONVERT;
                    cnt_d   = CONV_LAST;
                    chain_d = ~cs_sel;
                    start_d = 1'b0;
                    // [RULE15] Clock low: no busy
                    // [RULE20] Clock high: busy enabled
                    busy_en_d = ~cs_sel & sck_s2_q;
                end else if (trig_fall) begin
                    state_d = ASR_IDLE;
                end
            end
            default: begin
                state_d = ASR_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Output pin logic
    // ****************************************************************
    always_comb begin
        out_d = 1'b0;
        oe_d  = 1'b0;
        case (state_d)
            ASR_CONVERT: begin
                // [RULE3] Select mode floats output
                oe_d = chain_d;
            end
            ASR_READY: begin
                if (chain_d) begin
                    // [RULE17] MSB at completion
                    // [RULE21] Ready shown high
                    oe_d  = 1'b1;
                    out_d = start_d ? 1'b1 : sh_next_msb;
                end else begin
                    // [RULE8] Busy start bit low
                    // [RULE10] Select low shows MSB
                    oe_d  = ~sel_s2_q | busy_en_d;
                    out_d = start_d ? 1'b0 : sh_next_msb;
                end
            end
            ASR_IDLE, ASR_RELEASED: begin
                // [RULE5] Both low drive low
                oe_d = ~trig_s2_q & ~sel_s2_q;
            end
            default: begin
                oe_d = 1'b0;
            end
        endcase
    end

    // Shifter updates on the same edge as the output flop, so the next
    // MSB is predicted here to keep the pin aligned with the falls

    always_comb begin
        if (sh.load) begin
            sh_next_msb = sh.load_val[DATA_W-1];
        end else if (sh.shift) begin
            sh_next_msb = sh_mirror_q[DATA_W-2];
        end else begin
            sh_next_msb = sh.msb;
        end
    end

    // Mirror of the shifter contents, needed for the look-ahead bit
    always_ff @(posedge clk) begin
        if (reset) begin
            sh_mirror_q <= '0;
        end else if (clk_en) begin
            if (sh.load) begin
                sh_mirror_q <= sh.load_val;
            end else if (sh.shift) begin
                sh_mirror_q <= {sh_mirror_q[DATA_W-2:0], sh.ser_in};
            end
        end
    end

    // ****************************************************************
    // State and output registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q   <= ASR_IDLE;
            chain_q   <= 1'b0;
            busy_en_q <= 1'b0;
            start_q   <= 1'b0;
            cnt_q     <= 16'h0000;
            bits_q    <= `ASR_BITCNT_RESET;
            out_q     <= 1'b0;
            oe_q      <= 1'b0;
        end else if (clk_en) begin
            state_q   <= state_d;
            chain_q   <= chain_d;
            busy_en_q <= busy_en_d;
            start_q   <= start_d;
            cnt_q     <= cnt_d;
            bits_q    <= bits_d;
            out_q     <= out_d;
            oe_q      <= oe_d;
        end
    end

    logic active_q;
    logic chain_out_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            active_q    <= 1'b0;
            chain_out_q <= 1'b0;
        end else if (clk_en) begin
            active_q    <= (state_d == ASR_CONVERT);
            chain_out_q <= chain_d;
        end
    end

    assign result_out    = out_q;
    assign result_out_oe = oe_q;
    assign conv_active   = active_q;
    assign chain_mode    = chain_out_q;

endmodule

// ===== testbench/asr_readout_props.sv
module asr_readout_checker #(
    parameter int CONV_CYCLES = 8,
    parameter int DATA_W      = 16
) (
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              clk_en,
    input wire logic              conv_trigger,
    input wire logic              chain_in_select,
    input wire logic              sck,
    input wire logic [DATA_W-1:0] sample_data,
    input wire logic              result_out,
    input wire logic              result_out_oe,
    input wire logic              conv_active,
    input wire logic              chain_mode
);
    localparam int LO = CONV_CYCLES - 1;
    localparam int HI = CONV_CYCLES + 2;
    logic trig_q;
    logic busy_q;

    // Shift clock level at the trigger rise picks the chain start bit
    always_ff @(posedge clk) begin
        trig_q <= conv_trigger;
        if (reset) begin
            busy_q <= 1'b0;
        end else if (conv_trigger && !trig_q) begin
            busy_q <= sck;
        end
    end

    default clocking @(posedge clk); endclocking
    // Frozen design state is not held to the timing rules
    default disable iff (reset || !clk_en);

    sequence s_done;
        $fell(conv_active);
    endsequence
    sequence s_sel_rise;
        conv_trigger && !chain_mode && $rose(chain_in_select);
    endsequence

    AST_IDLE_LOW: assert property (
        (!conv_trigger && !chain_in_select)[*6]
        |-> result_out_oe && !result_out) else $error("idle pin not low");
    AST_SEL_FLOAT: assert property (
        conv_active && $past(conv_active) && !chain_mode
        |-> !result_out_oe) else $error("pin driven in select conversion");
    AST_CONV_LEN: assert property (
        $rose(conv_active) |-> ##[LO:HI] s_done)
        else $error("conversion length wrong");
    AST_MODE_HOLD: assert property (
        conv_active && $past(conv_active) |-> $stable(chain_mode))
        else $error("mode changed in conversion");
    AST_CHAIN_FIRST: assert property (
        s_done ##0 chain_mode |-> ##[0:2] (result_out_oe
        && result_out == (busy_q | sample_data[DATA_W-1])))
        else $error("chain first bit wrong");
    AST_SEL_BUSY: assert property (
        s_done ##0 (!chain_mode && !chain_in_select)
        |-> ##[0:2] (result_out_oe && !result_out))
        else $error("select busy bit missing");
    AST_START_CAUSE: assert property (
        $rose(conv_active) |-> $past(conv_trigger, 2))
        else $error("conversion without trigger");
    AST_SEL_RELEASE: assert property (
        s_sel_rise |-> ##[1:6] !result_out_oe)
        else $error("pin not released on select");
    AST_BIT_STANDS: assert property (
        $rose(sck) && result_out_oe |=> ##1 $stable(result_out)[*3])
        else $error("bit changed around clock high");
endmodule

bind asr_readout asr_readout_checker #(
    .CONV_CYCLES(CONV_CYCLES), .DATA_W(DATA_W)
) u_chk (
    .clk(clk), .reset(reset), .clk_en(clk_en),
    .conv_trigger(conv_trigger), .chain_in_select(chain_in_select),
    .sck(sck), .sample_data(sample_data), .result_out(result_out),
    .result_out_oe(result_out_oe), .conv_active(conv_active),
    .chain_mode(chain_mode)
);

// ===== testbench/asr_host_model.sv
module asr_host_model (
    input  wire logic       clk,
    input  wire logic       result_out,
    input  wire logic       result_out_oe,
    output      logic       conv_trigger,
    output      logic       chain_in_select,
    output      logic       sck,
    output      logic       cap_stb,
    output      logic [1:0] cap_val
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released pin is pulled up, so a float never reads as a stale bit
    wire line = result_out_oe ? result_out : 1'b1;

    initial begin
        {conv_trigger, chain_in_select, sck, cap_stb} = 4'h0;
        cap_val = 2'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic capture();
        cap_val <= {result_out_oe, line};
        cap_stb <= 1'b1;
        tick(1);
        cap_stb <= 1'b0;
    endtask
    task automatic trig(input logic s0, input logic k0, input logic s1);
        chain_in_select <= s0;
        sck <= k0;
        tick(2);
        conv_trigger <= 1'b1;
        tick(6);
        chain_in_select <= s1;
        tick(16);
        chain_in_select <= 1'b0;
        tick(6);
    endtask
    // Clock high 4 cycles, low 4 cycles: 800 ns at a 100 ns system clock
    task automatic read(input int n, input logic ch, input logic [31:0] up);
        for (int i = 0; i < n; i++) begin
            sck <= 1'b1;
            if (ch) begin
                chain_in_select <= up[31-i];
            end
            tick(2);
            capture();
            tick(1);
            sck <= 1'b0;
            tick(4);
        end
        tick(3);
        capture();
    endtask
    task automatic done();
        chain_in_select <= 1'b1;
        tick(8);
        conv_trigger <= 1'b0;
        tick(4);
        chain_in_select <= 1'b0;
        tick(8);
        capture();
    endtask
endmodule

// ===== testbench/tb_adc_serial_readout_modes.sv
module tb_adc_serial_readout_modes;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CONV = 8;
    logic        clk;
    logic        reset;
    logic        clk_en;
    logic [15:0] sample_data;
    logic [31:0] up;
    logic [47:0] st;
    logic [1:0]  e;
    logic [1:0]  exp_q[$];
    int          n_fail;
    int          tests_run;
    int          seed;
    wire         trg, sel, sck, dout, doe, busy, chm, stb;
    wire  [1:0]  cval;

    asr_readout #(.CONV_CYCLES(CONV), .DATA_W(16)) DUT (
        .clk(clk), .reset(reset), .clk_en(clk_en), .conv_trigger(trg),
        .chain_in_select(sel), .sck(sck), .sample_data(sample_data),
        .result_out(dout), .result_out_oe(doe), .conv_active(busy),
        .chain_mode(chm));
    asr_host_model host (
        .clk(clk), .result_out(dout), .result_out_oe(doe),
        .conv_trigger(trg), .chain_in_select(sel), .sck(sck),
        .cap_stb(stb), .cap_val(cval));

    task automatic fail(input string m);
        n_fail++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Modes: 0 select, 1 select busy, 2 chain, 3 chain busy
    task automatic scen(input int m, input logic cut);
        int nb;
        int full;
        sample_data <= 16'($random(seed));
        up = $random(seed);
        @(posedge clk);
        st = (m == 0) ? {sample_data, 32'h0} :
             (m == 1) ? {1'b0, sample_data, 31'h0} :
             (m == 2) ? {sample_data, up} : {1'b1, sample_data, up[30:0]};
        full = (m == 2) ? 32 : (m == 0) ? 16 : 17;
        // A cut select read is ended by the select rise in done
        nb = cut ? 8 : full;
        for (int k = 0; k <= nb; k++) begin
            exp_q.push_back((m < 2 && k == full) ? 2'h0 : {1'b1, st[47-k]});
        end
        exp_q.push_back(2'h2);
        host.trig(m < 2, m == 3, m == 0);
        tests_run++;
        if (chm !== (m > 1) || busy !== 1'b0) begin
            fail("mode flag or conversion state");
        end
        host.read(nb, m > 1, up);
        host.done();
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (stb === 1'b1) begin
            tests_run++;
            if (exp_q.size() == 0) begin
                fail("capture without note");
            end else begin
                e = exp_q.pop_front();
                // A released pin reads the pull-up level
                if (e[1] == 1'b0) begin
                    e[0] = 1'b1;
                end
                if (cval !== e) begin
                    fail("serial pin value");
                end
            end
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail("run did not finish");
        finish_test();
    end
    initial begin
        seed = 32'h62F9;
        reset = 1'b1;
        clk_en = 1'b1;
        sample_data = 16'h0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        for (int r = 0; r < 3; r++) begin
            for (int m = 0; m < 4; m++) begin
                scen(m, r == 1 && m < 2);
            end
        end
        // Clock enable low must freeze the idle pin drive
        clk_en <= 1'b0;
        host.chain_in_select <= 1'b1;
        repeat (6) @(posedge clk);
        tests_run++;
        if (doe !== 1'b1) begin
            fail("pin state moved with clock enable low");
        end
        clk_en <= 1'b1;
        repeat (6) @(posedge clk);
        tests_run++;
        if (doe !== 1'b0) begin
            fail("select high did not float the idle pin");
        end
        host.chain_in_select <= 1'b0;
        repeat (8) @(posedge clk);
        if (exp_q.size() != 0) begin
            fail("notes left over");
        end
        finish_test();
    end
endmodule
